/* bsa_bus_adapter.sv */
// System bus adapter between the bus and three channel engines
// Notes on behaviour
// - Slave port takes 32-bit programmed I/O only
// - Two 64-byte write buffers hold engine DMA
// - Round-robin arbitration among the three engines
// - Engine interrupts go straight to bus
// - Adapter holds no software-visible registers
// - Master does 64/32-bit mode, byte/half/word
// - Master bursts span 8 to 64 bytes
// - No atomic transactions, no bus sizing
// - Slave takes single byte/half/word, no bursts
// - Slave never uses late error line
// - Slave never answers with rerun code
// - Slave answers within 21 bus clocks
// - Engine's transfer size issued unchanged
// - Engine side: shared plus dedicated signals
// - Slave write, slave read, DMA write
// - Three-bit acknowledge code meanings
// - Odd parity generated and checked on data
// - Request bus, start only after grant
// - Everything sampled on bus clock rise
// - Virtual address on data lines
// - Master size line encoding
// - Direction low for master write
`default_nettype none
module bsa_bus_adapter #(
  parameter int SLV_WAIT = bsa_pkg::SLV_WAIT_MAX
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic bus_mode64_in,
  output logic bus_request_out,
  input wire logic bus_grant_in,
  input wire logic [31:0] bus_data_lines_in,
  output logic [31:0] bus_data_lines_out,
  output logic bus_data_lines_oe_out,
  output logic [31:0] bus_data_hi_out,
  input wire logic bus_odd_parity_in,
  output logic bus_odd_parity_out,
  output logic bus_odd_parity_oe_out,
  input wire logic [2:0] transfer_size_code_in,
  output logic [2:0] transfer_size_code_out,
  output logic transfer_size_code_oe_out,
  input wire logic transfer_direction_in,
  output logic transfer_direction_out,
  output logic transfer_direction_oe_out,
  input wire logic [2:0] slave_ack_code_in,
  output logic [2:0] slave_ack_code_out,
  output logic slave_ack_code_oe_out,
  input wire logic late_error_in,
  input wire logic slave_select_in,
  input wire logic address_strobe_in,
  input wire logic [27:0] physical_address_lines_in,
  input wire logic parity_check_en_in,
  output logic parity_error_out,
  output logic [2:0] bus_irq_out,
  input wire logic [2:0] eng_irq_in,
  input wire logic [2:0] dma_req_in,
  input wire logic [2:0][2:0] dma_size_in,
  input wire logic [2:0][31:0] dma_vaddr_in,
  input wire logic [2:0][63:0] dma_data_in,
  input wire logic [2:0] dma_valid_in,
  output logic [2:0] dma_ready_out,
  output logic [2:0] dma_grant_out,
  output logic [2:0] dma_done_out,
  output logic [2:0] dma_err_out,
  output logic [25:0] pio_addr_out,
  output logic [31:0] pio_wdata_out,
  output logic [2:0] pio_size_out,
  output logic pio_write_out,
  output logic [2:0] pio_sel_out,
  input wire logic [2:0] pio_ack_in,
  input wire logic [2:0] pio_err_in,
  input wire logic [2:0][31:0] pio_rdata_in
);
  localparam int NE = bsa_pkg::NUM_ENG;
  localparam int WW = bsa_pkg::WBUF_WORDS;
  localparam int SL = bsa_pkg::ENG_SEL_LSB;

  if (SLV_WAIT < 1 || SLV_WAIT > bsa_pkg::SLV_LAT_LIMIT - 4) begin : g_chk
    $error("SLV_WAIT too large for the slave latency bound");
  end

  bsa_pkg::bsa_mst_e mst_ff;
  bsa_pkg::bsa_slv_e slv_ff;
  logic [1:0] rr_ptr_ff;
  logic [2:0] eng_busy_ff;
  logic [1:0] buf_full_ff;
  logic fill_active_ff;
  logic fill_buf_ff;
  logic [1:0] fill_eng_ff;
  logic [3:0] fill_total_ff;
  logic [3:0] sent_cnt_ff;
  logic [3:0] wr_cnt_ff;
  logic [2:0] desc_size_ff [2];
  logic [31:0] desc_va_ff [2];
  logic [1:0] desc_eng_ff [2];
  logic [63:0] wbuf_mem_ff [2][WW];
  logic drn_buf_ff;
  logic mode64_ff;
  logic [4:0] beat_ff;
  logic m_err_ff;
  logic [27:0] slv_addr_ff;
  logic [2:0] slv_size_ff;
  logic slv_rd_ff;
  logic [31:0] slv_wdata_ff;
  logic [31:0] slv_rdata_ff;
  logic [2:0] slv_ack_ff;
  logic [4:0] slv_cnt_ff;
  logic perr_ff;
  logic [2:0] elig;
  logic arb_found;
  logic [1:0] arb_idx;
  logic grant_go;
  logic up_fire;
  logic dn_fire;
  logic [1:0] drn_eng;
  logic [4:0] beats;
  logic [6:0] drn_bytes;
  logic [63:0] cur_word;
  logic [1:0] slv_eng;
  logic m_ack_data;

  bsa_stream_if #(.W(64)) s_in();
  bsa_stream_if #(.W(64)) s_out();

  // Engine data passes a two-entry buffer so a stall loses no word
  bsa_pair_buf #(.W(64)) u_buf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .up(s_in.snk),
    .dn(s_out.src)
  );

  assign bus_irq_out = eng_irq_in;

  // Extended or unknown size codes are never granted
  generate
    for (genvar e = 0; e < NE; e++) begin : g_eng
      assign elig[e] = dma_req_in[e] & ~eng_busy_ff[e] &
        (bsa_pkg::bsa_size_bytes(dma_size_in[e]) != 7'h00);
      assign dma_grant_out[e] = grant_go & (arb_idx == 2'(e));
      assign dma_ready_out[e] = fill_active_ff & (fill_eng_ff == 2'(e)) &
        s_in.ready & (sent_cnt_ff < fill_total_ff);
      assign dma_done_out[e] = (mst_ff == bsa_pkg::M_DONE) &
        (drn_eng == 2'(e));
      assign dma_err_out[e] = dma_done_out[e] & m_err_ff;
      assign pio_sel_out[e] = (slv_ff == bsa_pkg::S_WAIT) &
        (slv_eng == 2'(e));
    end
  endgenerate

  always_comb begin
    logic [2:0] cand;
    cand = 3'h0;
    arb_found = 1'b0;
    arb_idx = 2'h0;
    for (int k = NE - 1; k >= 0; k--) begin
      cand = {1'b0, rr_ptr_ff} + 3'(k);
      if (cand >= 3'(NE)) begin
        cand = cand - 3'(NE);
      end
      if (elig[cand[1:0]]) begin
        arb_found = 1'b1;
        arb_idx = cand[1:0];
      end
    end
  end

  // A free buffer is needed before a winner may fill it
  assign grant_go = arb_found & ~fill_active_ff & ~buf_full_ff[fill_buf_ff];
  assign s_in.valid = fill_active_ff & dma_valid_in[fill_eng_ff] &
    (sent_cnt_ff < fill_total_ff);
  assign s_in.data = dma_data_in[fill_eng_ff];
  assign s_out.ready = fill_active_ff & (wr_cnt_ff < fill_total_ff);
  assign up_fire = s_in.valid & s_in.ready;
  assign dn_fire = s_out.valid & s_out.ready;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fill_active_ff <= 1'b0;
      fill_buf_ff <= 1'b0;
      fill_eng_ff <= 2'h0;
      fill_total_ff <= 4'h0;
      sent_cnt_ff <= 4'h0;
      wr_cnt_ff <= 4'h0;
      desc_size_ff <= '{default: 3'h0};
      desc_va_ff <= '{default: 32'h0};
      desc_eng_ff <= '{default: 2'h0};
    end else if (grant_go) begin
      fill_active_ff <= 1'b1;
      fill_eng_ff <= arb_idx;
      fill_total_ff <= bsa_pkg::bsa_words64(dma_size_in[arb_idx]);
      sent_cnt_ff <= 4'h0;
      wr_cnt_ff <= 4'h0;
      desc_size_ff[fill_buf_ff] <= dma_size_in[arb_idx];
      desc_va_ff[fill_buf_ff] <= dma_vaddr_in[arb_idx];
      desc_eng_ff[fill_buf_ff] <= arb_idx;
    end else if (fill_active_ff) begin
      if (up_fire) begin
        sent_cnt_ff <= sent_cnt_ff + 4'h1;
      end
      if (dn_fire) begin
        wr_cnt_ff <= wr_cnt_ff + 4'h1;
        if (wr_cnt_ff + 4'h1 == fill_total_ff) begin
          fill_active_ff <= 1'b0;
          fill_buf_ff <= ~fill_buf_ff;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (dn_fire) begin
      wbuf_mem_ff[fill_buf_ff][wr_cnt_ff[2:0]] <= s_out.data;
    end
  end

  // Fill and drain never address the same buffer in one cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buf_full_ff <= 2'h0;
    end else begin
      if (dn_fire && wr_cnt_ff + 4'h1 == fill_total_ff) begin
        buf_full_ff[fill_buf_ff] <= 1'b1;
      end
      if (mst_ff == bsa_pkg::M_DONE) begin
        buf_full_ff[drn_buf_ff] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      eng_busy_ff <= 3'h0;
    end else begin
      eng_busy_ff <= (eng_busy_ff | dma_grant_out) & ~dma_done_out;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rr_ptr_ff <= 2'h0;
    end else if (mst_ff == bsa_pkg::M_DONE) begin
      rr_ptr_ff <= (drn_eng == 2'(NE - 1)) ? 2'h0 : drn_eng + 2'h1;
    end
  end

  assign drn_eng = desc_eng_ff[drn_buf_ff];
  assign drn_bytes = bsa_pkg::bsa_size_bytes(desc_size_ff[drn_buf_ff]);
  // Beats follow the engine's size exactly; no sizing to the slave width
  assign beats = mode64_ff
    ? {1'b0, bsa_pkg::bsa_words64(desc_size_ff[drn_buf_ff])}
    : ((drn_bytes <= 7'h04) ? 5'h01 : drn_bytes[6:2]);
  assign cur_word = wbuf_mem_ff[drn_buf_ff]
    [mode64_ff ? beat_ff[2:0] : beat_ff[3:1]];
  assign m_ack_data = slave_ack_code_in == bsa_pkg::ACK_BYTE ||
    slave_ack_code_in == bsa_pkg::ACK_HALF ||
    slave_ack_code_in == bsa_pkg::ACK_WORD ||
    slave_ack_code_in == bsa_pkg::ACK_DWORD;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mst_ff <= bsa_pkg::M_IDLE;
      drn_buf_ff <= 1'b0;
      mode64_ff <= 1'b0;
      beat_ff <= 5'h00;
      m_err_ff <= 1'b0;
    end else begin
      unique case (mst_ff)
        bsa_pkg::M_IDLE: begin
          m_err_ff <= 1'b0;
          if (buf_full_ff[drn_buf_ff]) begin
            mode64_ff <= bus_mode64_in;
            mst_ff <= bsa_pkg::M_REQ;
          end
        end
        bsa_pkg::M_REQ: begin
          beat_ff <= 5'h00;
          if (bus_grant_in) begin
            mst_ff <= bsa_pkg::M_ADDR;
          end
        end
        bsa_pkg::M_ADDR: begin
          mst_ff <= bsa_pkg::M_DATA;
        end
        bsa_pkg::M_DATA: begin
          if (slave_ack_code_in == bsa_pkg::ACK_RERUN) begin
            mst_ff <= bsa_pkg::M_REQ;
          end else if (m_ack_data) begin
            if (beat_ff + 5'h01 == beats) begin
              mst_ff <= bsa_pkg::M_LERR;
            end else begin
              beat_ff <= beat_ff + 5'h01;
            end
          end else if (slave_ack_code_in != bsa_pkg::ACK_IDLE) begin
            m_err_ff <= 1'b1;
            mst_ff <= bsa_pkg::M_DONE;
          end
        end
        bsa_pkg::M_LERR: begin
          if (late_error_in) begin
            m_err_ff <= 1'b1;
          end
          mst_ff <= bsa_pkg::M_DONE;
        end
        bsa_pkg::M_DONE: begin
          drn_buf_ff <= ~drn_buf_ff;
          mst_ff <= bsa_pkg::M_IDLE;
        end
        default: mst_ff <= bsa_pkg::M_IDLE;
      endcase
    end
  end

  assign bus_request_out = mst_ff == bsa_pkg::M_REQ;

  // Master owns the lines once granted; slave drives only its answer
  always_comb begin
    bus_data_lines_out = 32'h0;
    bus_data_hi_out = 32'h0;
    bus_data_lines_oe_out = 1'b0;
    if (mst_ff == bsa_pkg::M_ADDR) begin
      bus_data_lines_out = desc_va_ff[drn_buf_ff];
      bus_data_lines_oe_out = 1'b1;
    end else if (mst_ff == bsa_pkg::M_DATA) begin
      bus_data_lines_oe_out = 1'b1;
      if (mode64_ff) begin
        bus_data_lines_out = cur_word[31:0];
        bus_data_hi_out = cur_word[63:32];
      end else if (beats > 5'h01 && !beat_ff[0]) begin
        bus_data_lines_out = cur_word[63:32];
      end else begin
        bus_data_lines_out = cur_word[31:0];
      end
    end else if (slv_ff == bsa_pkg::S_ACK && slv_rd_ff) begin
      bus_data_lines_out = slv_rdata_ff;
      bus_data_lines_oe_out = 1'b1;
    end
  end

  assign bus_odd_parity_out = bsa_pkg::bsa_odd_par(bus_data_lines_out);
  assign bus_odd_parity_oe_out = bus_data_lines_oe_out;
  assign transfer_size_code_out = desc_size_ff[drn_buf_ff];
  assign transfer_size_code_oe_out = mst_ff == bsa_pkg::M_ADDR ||
    mst_ff == bsa_pkg::M_DATA;
  assign transfer_direction_out = 1'b0;
  assign transfer_direction_oe_out = transfer_size_code_oe_out;
  assign slave_ack_code_out = slv_ack_ff;
  assign slave_ack_code_oe_out = slv_ff == bsa_pkg::S_ACK;

  assign slv_eng = slv_addr_ff[bsa_pkg::PA_W-1:SL];
  assign pio_addr_out = slv_addr_ff[SL-1:0];
  assign pio_wdata_out = slv_wdata_ff;
  assign pio_size_out = slv_size_ff;
  assign pio_write_out = ~slv_rd_ff;
  assign parity_error_out = perr_ff;

  // Refusals and timeouts go out as an error code, parity errors only on parity_error_out; late error is never driven
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slv_ff <= bsa_pkg::S_IDLE;
      slv_addr_ff <= 28'h0;
      slv_size_ff <= 3'h0;
      slv_rd_ff <= 1'b0;
      slv_wdata_ff <= 32'h0;
      slv_rdata_ff <= 32'h0;
      slv_ack_ff <= 3'h0;
      slv_cnt_ff <= 5'h00;
      perr_ff <= 1'b0;
    end else begin
      perr_ff <= 1'b0;
      unique case (slv_ff)
        bsa_pkg::S_IDLE: begin
          if (address_strobe_in && slave_select_in) begin
            slv_addr_ff <= physical_address_lines_in;
            slv_size_ff <= transfer_size_code_in;
            slv_rd_ff <= transfer_direction_in;
            slv_ff <= bsa_pkg::S_LATCH;
          end
        end
        bsa_pkg::S_LATCH: begin
          slv_wdata_ff <= bus_data_lines_in;
          slv_cnt_ff <= 5'h00;
          if (!slv_rd_ff && parity_check_en_in &&
              !(^{bus_data_lines_in, bus_odd_parity_in})) begin
            perr_ff <= 1'b1;
          end
          if (!bsa_pkg::bsa_is_single(slv_size_ff) ||
              slv_eng == 2'(NE)) begin
            slv_ack_ff <= bsa_pkg::ACK_ERR;
            slv_ff <= bsa_pkg::S_ACK;
          end else begin
            slv_ff <= bsa_pkg::S_WAIT;
          end
        end
        bsa_pkg::S_WAIT: begin
          if (pio_ack_in[slv_eng]) begin
            slv_rdata_ff <= pio_rdata_in[slv_eng];
            slv_ack_ff <= pio_err_in[slv_eng] ? bsa_pkg::ACK_ERR
              : bsa_pkg::bsa_ack_for(slv_size_ff);
            slv_ff <= bsa_pkg::S_ACK;
          end else if (slv_cnt_ff == 5'(SLV_WAIT)) begin
            slv_ack_ff <= bsa_pkg::ACK_ERR;
            slv_ff <= bsa_pkg::S_ACK;
          end else begin
            slv_cnt_ff <= slv_cnt_ff + 5'h01;
          end
        end
        bsa_pkg::S_ACK: begin
          slv_ff <= bsa_pkg::S_IDLE;
        end
        default: slv_ff <= bsa_pkg::S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_slv_latency;
    (slv_ff == bsa_pkg::S_IDLE) && address_strobe_in && slave_select_in
      |-> ##[2:21] slave_ack_code_oe_out;
  endproperty
  a_slv_latency: assert property (p_slv_latency)
    else $error("slave answer later than 21 clocks");

  property p_no_rerun;
    slave_ack_code_oe_out |-> slave_ack_code_out != bsa_pkg::ACK_RERUN &&
      slave_ack_code_out != bsa_pkg::ACK_RSVD && slave_ack_code_out != 3'h0;
  endproperty
  a_no_rerun: assert property (p_no_rerun)
    else $error("slave answered with rerun or non-final code");

  property p_no_burst_slave;
    (slv_ff == bsa_pkg::S_LATCH) && !bsa_pkg::bsa_is_single(slv_size_ff)
      |=> slave_ack_code_oe_out && slave_ack_code_out == bsa_pkg::ACK_ERR;
  endproperty
  a_no_burst_slave: assert property (p_no_burst_slave)
    else $error("slave burst not refused by error code");

  property p_grant_first;
    $rose(transfer_size_code_oe_out) |-> $past(bus_grant_in) &&
      $past(bus_request_out);
  endproperty
  a_grant_first: assert property (p_grant_first)
    else $error("master started without request and grant");

  property p_size_legal;
    transfer_size_code_oe_out |-> transfer_size_code_out != bsa_pkg::SIZ_EXT
      && !transfer_direction_out;
  endproperty
  a_size_legal: assert property (p_size_legal)
    else $error("master issued extended size or read");

  property p_exact_size;
    transfer_size_code_oe_out && $past(transfer_size_code_oe_out) |->
      $stable(transfer_size_code_out);
  endproperty
  a_exact_size: assert property (p_exact_size)
    else $error("size code changed within a transfer");

  property p_parity;
    bus_data_lines_oe_out |-> ^{bus_data_lines_out, bus_odd_parity_out};
  endproperty
  a_parity: assert property (p_parity)
    else $error("driven parity not odd");

  property p_irq_pass;
    bus_irq_out == eng_irq_in;
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("interrupt not passed straight through");

  property p_err_ends;
    (mst_ff == bsa_pkg::M_DATA) && slave_ack_code_in == bsa_pkg::ACK_ERR
      |=> (mst_ff == bsa_pkg::M_DONE) && (dma_err_out != 3'h0)
      ##1 mst_ff == bsa_pkg::M_IDLE;
  endproperty
  a_err_ends: assert property (p_err_ends)
    else $error("error acknowledge did not end transfer");

  property p_rr_step;
    (mst_ff == bsa_pkg::M_DONE) && drn_eng == 2'h0 |=> rr_ptr_ff == 2'h1;
  endproperty
  a_rr_step: assert property (p_rr_step)
    else $error("round-robin pointer not advanced after service");

  property p_rr_hold;
    mst_ff != bsa_pkg::M_DONE |=> $stable(rr_ptr_ff);
  endproperty
  a_rr_hold: assert property (p_rr_hold)
    else $error("round-robin pointer moved without acknowledge");

  c_slv_read: cover property (slave_ack_code_oe_out && slv_rd_ff &&
    slave_ack_code_out == bsa_pkg::ACK_WORD);
  c_slv_timeout: cover property ((slv_ff == bsa_pkg::S_WAIT) &&
    slv_cnt_ff == 5'(SLV_WAIT));
  c_burst64: cover property ((mst_ff == bsa_pkg::M_LERR) &&
    desc_size_ff[drn_buf_ff] == bsa_pkg::SIZ_B64);
  c_rerun: cover property ((mst_ff == bsa_pkg::M_DATA) &&
    slave_ack_code_in == bsa_pkg::ACK_RERUN);
endmodule // bsa_bus_adapter
`default_nettype wire

/* bsa_bus_adapter_tb.sv */
// Self-checking bench for the bus adapter
`default_nettype none
module bsa_bus_adapter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, nrst_in = 1'b0, bus_mode64_in = 1'b0;
  logic late_error_in = 1'b0, parity_check_en_in = 1'b1;
  logic bus_odd_parity_in = 1'b1, transfer_direction_in = 1'b0;
  logic slave_select_in = 1'b0, address_strobe_in = 1'b0;
  logic bus_request_out, bus_grant_in, bus_data_lines_oe_out;
  logic bus_odd_parity_out, bus_odd_parity_oe_out, transfer_direction_out;
  logic transfer_size_code_oe_out, transfer_direction_oe_out;
  logic slave_ack_code_oe_out, parity_error_out, pio_write_out;
  logic [2:0] transfer_size_code_in = '0, transfer_size_code_out;
  logic [2:0] slave_ack_code_in, slave_ack_code_out, bus_irq_out, last_siz;
  logic [2:0] eng_irq_in = '0, dma_req_in = '0, dma_valid_in = '0;
  logic [2:0] dma_ready_out, dma_grant_out, dma_done_out, dma_err_out;
  logic [2:0] pio_size_out, pio_sel_out, pio_ack_in = '0, pio_err_in = '0;
  logic [31:0] bus_data_lines_out, bus_data_hi_out, pio_wdata_out;
  logic [31:0] tb_data = '0;
  logic [31:0] last_va, rx_hi;
  logic [63:0] rx_data;
  logic [1:0] last_dir;
  logic ack_err = 1'b0;
  wire logic [31:0] bus_data_lines_in;
  logic [27:0] physical_address_lines_in = '0;
  logic [25:0] pio_addr_out;
  logic [2:0][2:0] dma_size_in = '0;
  logic [2:0][31:0] dma_vaddr_in = '0, pio_rdata_in;
  logic [2:0][63:0] dma_data_in = '0;
  int error_cnt = 0, total_checks = 0;

  always #20 clk_in = ~clk_in;
  assign bus_data_lines_in = bus_data_lines_oe_out ? bus_data_lines_out
                                                   : tb_data;
  assign pio_rdata_in = {32'hc0de0002, 32'hc0de0001, 32'hc0de0000};
  // Engines answer one cycle after being selected
  always @(posedge clk_in) pio_ack_in <= pio_sel_out & ~pio_ack_in;
  // Address cycle carries no acknowledge; each acked beat shifts in
  always @(posedge clk_in) begin
    if (transfer_size_code_oe_out) begin
      last_siz <= transfer_size_code_out;
      last_dir <= {transfer_direction_oe_out, transfer_direction_out};
      if (slave_ack_code_in == bsa_pkg::ACK_IDLE) begin
        last_va <= bus_data_lines_out;
      end else begin
        rx_data <= {rx_data[31:0], bus_data_lines_out};
        rx_hi <= bus_data_hi_out;
      end
    end
  end

  bsa_bus_adapter i_dut (.*);
  bsa_ctl_model i_ctl (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(bus_request_out), .xfer_oe_in(transfer_size_code_oe_out),
    .mode64_in(bus_mode64_in), .err_in(ack_err),
    .grant_out(bus_grant_in), .ack_out(slave_ack_code_in));

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic t_idle;
    #1;
    chk("request", 0, bus_request_out);
    chk("ack oe", 0, slave_ack_code_oe_out);
    @(posedge clk_in);
    eng_irq_in <= 3'h5;
    #1;
    chk("irq", 3'h5, bus_irq_out);
  endtask

  // One single access; latency counted from the strobe edge
  task automatic t_slave(input logic [1:0] e, input logic [2:0] s,
                         input logic r, input logic [2:0] exp);
    int n;
    logic pe;
    @(posedge clk_in);
    address_strobe_in <= 1'b1;
    slave_select_in <= 1'b1;
    physical_address_lines_in <= {e, 26'h40};
    transfer_size_code_in <= s;
    transfer_direction_in <= r;
    tb_data <= 32'h5a5a1234;
    @(posedge clk_in);
    address_strobe_in <= 1'b0;
    slave_select_in <= 1'b0;
    n = 0;
    pe = 1'b0;
    #1;
    while (slave_ack_code_oe_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
      pe |= parity_error_out;
    end
    chk("ack code", exp, slave_ack_code_out);
    chk("latency ok", 1, n <= 21);
    if (r && exp != bsa_pkg::ACK_ERR)
      chk("read data", pio_rdata_in[e], bus_data_lines_out);
    chk("parity error", !r && !(^{32'h5a5a1234, bus_odd_parity_in}),
        pe);
    chk("engine address", 26'h40, pio_addr_out);
    chk("engine size", s, pio_size_out);
    chk("engine write", !r, pio_write_out);
    if (!r)
      chk("engine data", 32'h5a5a1234, pio_wdata_out);
  endtask

  task automatic t_dma(input logic [1:0] e, input logic m64,
                       input logic [2:0] s, input logic err);
    int n;
    @(posedge clk_in);
    bus_mode64_in <= m64;
    ack_err <= err;
    dma_req_in <= 3'h1 << e;
    dma_size_in[e] <= s;
    dma_vaddr_in[e] <= 32'h00001000;
    dma_data_in[e] <= 64'h1122334455667788;
    // Valid stays up; the adapter takes only the words it asked for
    dma_valid_in <= 3'h1 << e;
    n = 0;
    #1;
    while (!(dma_valid_in[e] && dma_ready_out[e]) && n < 60) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    @(posedge clk_in);
    dma_req_in <= 3'h0;
    #1;
    while (dma_done_out[e] !== 1'b1 && n < 120) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("done", 1, dma_done_out[e]);
    chk("dma error", err, dma_err_out[e]);
    chk("size code", s, last_siz);
    chk("direction", 2'h2, last_dir);
    chk("virtual address", 32'h00001000, last_va);
    if (!err) begin
      chk("data high", 32'h11223344, m64 ? rx_hi : rx_data[63:32]);
      chk("data low", 32'h55667788, rx_data[31:0]);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_idle();
    t_slave(2'h1, bsa_pkg::SIZ_WORD, 1'b1, bsa_pkg::ACK_WORD);
    t_slave(2'h0, bsa_pkg::SIZ_BYTE, 1'b0, bsa_pkg::ACK_BYTE);
    t_slave(2'h2, bsa_pkg::SIZ_HALF, 1'b1, bsa_pkg::ACK_HALF);
    t_slave(2'h0, bsa_pkg::SIZ_B16, 1'b1, bsa_pkg::ACK_ERR);
    t_slave(2'h3, bsa_pkg::SIZ_WORD, 1'b1, bsa_pkg::ACK_ERR);
    t_dma(2'h0, 1'b0, bsa_pkg::SIZ_B8, 1'b0);
    t_dma(2'h1, 1'b1, bsa_pkg::SIZ_B16, 1'b0);
    t_dma(2'h2, 1'b0, bsa_pkg::SIZ_WORD, 1'b1);
    close_out();
  end

  // Whole run needs well under a hundred cycles; far more means a hang
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule // bsa_bus_adapter_tb
`default_nettype wire

/* bsa_ctl_model.sv */
// Behavioural bus controller: grants the bus and acknowledges beats
`default_nettype none
module bsa_ctl_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req_in,
  input wire logic xfer_oe_in,
  input wire logic mode64_in,
  input wire logic err_in,
  output logic grant_out,
  output logic [2:0] ack_out
);
  logic seen_ff;
  // Bus taken as always free, so grant follows a request by one cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) grant_out <= 1'b0;
    else grant_out <= req_in & ~grant_out;
  end
  // First driven cycle is the address, so it gets no acknowledge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) seen_ff <= 1'b0;
    else seen_ff <= xfer_oe_in;
  end
  // Beats answered by width, or refused when the bench asks for it
  assign ack_out = !(xfer_oe_in & seen_ff) ? bsa_pkg::ACK_IDLE :
                   err_in ? bsa_pkg::ACK_ERR :
                   mode64_in ? bsa_pkg::ACK_DWORD : bsa_pkg::ACK_WORD;
endmodule // bsa_ctl_model
`default_nettype wire

/* bsa_pair_buf.sv */
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module bsa_pair_buf #(
  parameter int W = 64
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  bsa_stream_if.snk up,
  bsa_stream_if.src dn
);
  if (W < 1) begin : g_chk
    $error("bsa_pair_buf width must be positive");
  end

  logic [W-1:0] mem_ff [2];
  logic wptr_ff;
  logic rptr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  // Ready depends only on occupancy, so no path from dn.ready to up.ready
  assign up.ready = cnt_ff != 2'h2;
  assign dn.valid = cnt_ff != 2'h0;
  assign dn.data = mem_ff[rptr_ff];
  assign push = up.valid & up.ready;
  assign pop = dn.valid & dn.ready;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wptr_ff] <= up.data;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wptr_ff <= ~wptr_ff;
      end
      if (pop) begin
        rptr_ff <= ~rptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // bsa_pair_buf
`default_nettype wire

/* bsa_pkg.sv */
// Shared constants, codes and helpers for the bus adapter
`default_nettype none
package bsa_pkg;
  localparam int NUM_ENG = 3;
  localparam int DATA_W = 32;
  localparam int PA_W = 28;
  localparam int ENG_SEL_LSB = 26;
  localparam int WBUF_BYTES = 64;
  localparam int WBUF_WORDS = WBUF_BYTES / 8;
  localparam int SLV_LAT_LIMIT = 22;
  // Strobe cycle, latch cycle and answer cycle surround the wait
  localparam int SLV_WAIT_MAX = SLV_LAT_LIMIT - 4;

  localparam logic [2:0] ACK_IDLE = 3'h0;
  localparam logic [2:0] ACK_ERR = 3'h1;
  localparam logic [2:0] ACK_BYTE = 3'h2;
  localparam logic [2:0] ACK_RERUN = 3'h3;
  localparam logic [2:0] ACK_WORD = 3'h4;
  localparam logic [2:0] ACK_DWORD = 3'h5;
  localparam logic [2:0] ACK_HALF = 3'h6;
  localparam logic [2:0] ACK_RSVD = 3'h7;

  localparam logic [2:0] SIZ_WORD = 3'h0;
  localparam logic [2:0] SIZ_BYTE = 3'h1;
  localparam logic [2:0] SIZ_HALF = 3'h2;
  localparam logic [2:0] SIZ_EXT = 3'h3;
  localparam logic [2:0] SIZ_B16 = 3'h4;
  localparam logic [2:0] SIZ_B32 = 3'h5;
  localparam logic [2:0] SIZ_B64 = 3'h6;
  localparam logic [2:0] SIZ_B8 = 3'h7;

  typedef enum logic [5:0] {
    M_IDLE = 6'h01, M_REQ = 6'h02, M_ADDR = 6'h04,
    M_DATA = 6'h08, M_LERR = 6'h10, M_DONE = 6'h20
  } bsa_mst_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_LATCH = 4'h2, S_WAIT = 4'h4, S_ACK = 4'h8
  } bsa_slv_e;

  // Bytes moved by a size code; zero for the extended code
  function automatic logic [6:0] bsa_size_bytes(input logic [2:0] code);
    case (code)
      SIZ_WORD: return 7'h04;
      SIZ_BYTE: return 7'h01;
      SIZ_HALF: return 7'h02;
      SIZ_B16: return 7'h10;
      SIZ_B32: return 7'h20;
      SIZ_B64: return 7'h40;
      SIZ_B8: return 7'h08;
      default: return 7'h00;
    endcase
  endfunction

  // 64-bit buffer words needed to hold a transfer
  function automatic logic [3:0] bsa_words64(input logic [2:0] code);
    logic [6:0] b;
    b = bsa_size_bytes(code);
    return (b <= 7'h08) ? 4'h1 : b[6:3];
  endfunction

  function automatic logic bsa_is_single(input logic [2:0] code);
    return code == SIZ_WORD || code == SIZ_BYTE || code == SIZ_HALF;
  endfunction

  function automatic logic [2:0] bsa_ack_for(input logic [2:0] code);
    case (code)
      SIZ_BYTE: return ACK_BYTE;
      SIZ_HALF: return ACK_HALF;
      default: return ACK_WORD;
    endcase
  endfunction

  // Parity bit that makes the data plus parity count odd
  function automatic logic bsa_odd_par(input logic [31:0] d);
    return ~(^d);
  endfunction
endpackage
`default_nettype wire

/* bsa_stream_if.sv */
// Valid/ready word stream between adapter modules
`default_nettype none
interface bsa_stream_if #(
  parameter int W = 64
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire
